// ---- logic/serial_power_ctrl.sv ----
// power-mode control for a three-driver, five-receiver serial transceiver
// assumes control pins and line detectors are asynchronous to sys_clk
// Function
// - power-down stops supply and floats transmitters
// - two-pin: receivers off only in manual power-down
// - single-pin: low power_down_n enters power-down
// - single-pin: receivers stay on in power-down
// - two-pin: force_sleep_n low forces manual power-down
// - two-pin: both control pins high: always running
// - two-pin manual power-down disables receivers
// - tied control pins never engage auto mode
// - transmission resumes within 100 us of wake
// - auto mode: no valid level 30 us after wake: sleep
// - line_valid high when any input valid
// - line_valid falls after over 30 us invalid
// - line_valid rises 1 us after valid
// - line_valid works in every mode
// - auto mode: low line_valid means powered down
// - auto mode: 30 us invalid powers down
// - auto mode: valid level wakes device
// - auto only with hold_awake low, sleep high
// - single-pin: rx_enable_n gates receivers always
// - monitor receiver output always active
`timescale 1ns/1ns
`default_nettype none
module serial_power_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_down_n,
  input wire logic rx_enable_n,
  input wire logic force_sleep_n,
  input wire logic hold_awake,
  input wire logic [serial_pd_pkg::N_RX-1:0] rx_line,
  input wire logic [serial_pd_pkg::N_RX-1:0] rx_level_valid,
  input wire logic [serial_pd_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [serial_pd_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [serial_pd_pkg::DATA_W-1:0] reg_rdata,
  output logic supply_on,
  output logic tx_oe,
  output logic [serial_pd_pkg::N_RX-1:0] rx_out,
  output logic rx_oe,
  output logic monitor_rx_out,
  output logic line_valid
);

  localparam int N_CTRL = 4;

  logic [N_CTRL-1:0] ctrl_sync;
  logic power_down_n_s;
  logic rx_enable_n_s;
  logic force_sleep_n_s;
  logic hold_awake_s;
  logic [serial_pd_pkg::N_RX-1:0] rx_line_s;
  logic [serial_pd_pkg::N_RX-1:0] rx_valid_s;
  logic [serial_pd_pkg::DATA_W-1:0] config_reg;
  logic two_pin;
  logic manual_req;
  logic auto_en;
  logic grace_done;
  logic resume_done;
  serial_pd_pkg::power_state_t state;
  serial_pd_pkg::power_state_t next_state;
  logic [serial_pd_pkg::CNT_W-1:0] grace_cnt;
  logic [serial_pd_pkg::CNT_W-1:0] resume_cnt;

  function automatic logic is_powered_down(input serial_pd_pkg::power_state_t s);
    is_powered_down = (s != serial_pd_pkg::ST_RUN);
  endfunction

  function automatic logic [1:0] mode_code(input serial_pd_pkg::power_state_t s);
    case (s)
      serial_pd_pkg::ST_RUN: mode_code = serial_pd_pkg::MODE_ACTIVE;
      serial_pd_pkg::ST_MANUAL_PD: mode_code = serial_pd_pkg::MODE_MANUAL;
      serial_pd_pkg::ST_AUTO_PD: mode_code = serial_pd_pkg::MODE_AUTO;
      default: mode_code = serial_pd_pkg::MODE_MANUAL;
    endcase
  endfunction

  // pin synchronisers
  pin_sync #(
    .WIDTH(N_CTRL)
  ) u_ctrl_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in({power_down_n, rx_enable_n, force_sleep_n, hold_awake}),
    .pin_sync_out(ctrl_sync)
  );

  pin_sync #(
    .WIDTH(serial_pd_pkg::N_RX)
  ) u_line_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(rx_line),
    .pin_sync_out(rx_line_s)
  );

  pin_sync #(
    .WIDTH(serial_pd_pkg::N_RX)
  ) u_valid_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(rx_level_valid),
    .pin_sync_out(rx_valid_s)
  );

  assign power_down_n_s = ctrl_sync[3];
  assign rx_enable_n_s = ctrl_sync[2];
  assign force_sleep_n_s = ctrl_sync[1];
  assign hold_awake_s = ctrl_sync[0];

  // line status runs regardless of power state
  line_valid_filter u_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .rx_valid(rx_valid_s),
    .line_valid(line_valid)
  );

  // register port
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      config_reg <= serial_pd_pkg::CONFIG_RESET;
    end else if (reg_wr && reg_addr == serial_pd_pkg::REG_CONFIG) begin
      config_reg <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= serial_pd_pkg::DATA_ZERO;
    end else begin
      reg_rdata <= serial_pd_pkg::DATA_ZERO;
      if (reg_rd && reg_addr == serial_pd_pkg::REG_CONFIG) begin
        reg_rdata <= config_reg;
      end else if (reg_rd && reg_addr == serial_pd_pkg::REG_STATUS) begin
        reg_rdata[serial_pd_pkg::ST_MODE_LSB +: 2] <= mode_code(state);
        reg_rdata[serial_pd_pkg::ST_VALID_BIT] <= line_valid;
        reg_rdata[serial_pd_pkg::ST_SUPPLY_BIT] <= supply_on;
        reg_rdata[serial_pd_pkg::ST_TX_BIT] <= tx_oe;
        reg_rdata[serial_pd_pkg::ST_RX_BIT] <= rx_oe;
      end
    end
  end

  assign two_pin = config_reg[serial_pd_pkg::CFG_TWO_PIN_BIT];

  // manual request per variant
  assign manual_req = two_pin ? !force_sleep_n_s : !power_down_n_s;
  // tied pins give sleep low or both high, so auto never engages
  assign auto_en = two_pin && force_sleep_n_s && !hold_awake_s;
  assign grace_done = (grace_cnt == serial_pd_pkg::CNT_ZERO);
  assign resume_done = (resume_cnt == serial_pd_pkg::RESUME_CYC);

  always_comb begin
    next_state = state;
    case (state)
      serial_pd_pkg::ST_RUN: begin
        if (manual_req) begin
          next_state = serial_pd_pkg::ST_MANUAL_PD;
        end else if (auto_en && !line_valid && grace_done) begin
          next_state = serial_pd_pkg::ST_AUTO_PD;
        end
      end
      serial_pd_pkg::ST_MANUAL_PD: begin
        if (!manual_req) begin
          next_state = serial_pd_pkg::ST_RUN;
        end
      end
      serial_pd_pkg::ST_AUTO_PD: begin
        if (manual_req) begin
          next_state = serial_pd_pkg::ST_MANUAL_PD;
        end else if (line_valid || !auto_en) begin
          next_state = serial_pd_pkg::ST_RUN;
        end
      end
      default: next_state = serial_pd_pkg::ST_MANUAL_PD;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= serial_pd_pkg::ST_MANUAL_PD;
    end else begin
      state <= next_state;
    end
  end

  // wake grace window before auto power-down may act
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      grace_cnt <= serial_pd_pkg::GRACE_CYC;
    end else if (is_powered_down(state)) begin
      grace_cnt <= serial_pd_pkg::GRACE_CYC;
    end else if (!grace_done) begin
      grace_cnt <= grace_cnt - serial_pd_pkg::CNT_ONE;
    end
  end

  // transmitter resume delay after supply start
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resume_cnt <= serial_pd_pkg::CNT_ZERO;
    end else if (is_powered_down(state)) begin
      resume_cnt <= serial_pd_pkg::CNT_ZERO;
    end else if (!resume_done) begin
      resume_cnt <= resume_cnt + serial_pd_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      supply_on <= 1'b0;
      tx_oe <= 1'b0;
    end else begin
      supply_on <= !is_powered_down(state);
      tx_oe <= !is_powered_down(state) && resume_done;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_oe <= 1'b0;
    end else if (two_pin) begin
      rx_oe <= (state != serial_pd_pkg::ST_MANUAL_PD);
    end else begin
      rx_oe <= !rx_enable_n_s;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_out <= '0;
      monitor_rx_out <= 1'b0;
    end else begin
      rx_out <= ~rx_line_s;
      monitor_rx_out <= rx_line_s[serial_pd_pkg::MON_IDX];
    end
  end

  // checking helpers: run counters mirror the filter's view of the inputs
  localparam int RESUME_LIM = serial_pd_pkg::T_RESUME_US * serial_pd_pkg::CLK_MHZ;
  localparam int PERSIST_LIM = serial_pd_pkg::T_PERSIST_US * serial_pd_pkg::CLK_MHZ;
  localparam int RECOVER_LIM = serial_pd_pkg::T_RECOVER_US * serial_pd_pkg::CLK_MHZ;
  // saturation keeps the run counters from wrapping on long idle spells
  localparam int RUN_SAT = 4000;
  logic any_valid_h;
  int invalid_run;
  int valid_run;
  int wake_age;

  assign any_valid_h = |rx_valid_s;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      invalid_run <= 0;
      valid_run <= 0;
      wake_age <= 0;
    end else begin
      invalid_run <= any_valid_h ? 0 : ((invalid_run < RUN_SAT) ? invalid_run + 1 : invalid_run);
      valid_run <= !any_valid_h ? 0 : ((valid_run < RUN_SAT) ? valid_run + 1 : valid_run);
      wake_age <= (supply_on && !tx_oe) ? wake_age + 1 : 0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_pd_tx_off: assert property (is_powered_down(state) |=> !tx_oe && !supply_on)
    else $error("transmitters or supply active in power-down");
  chk_manual_rx_off: assert property (two_pin && state == serial_pd_pkg::ST_MANUAL_PD
    |=> !rx_oe)
    else $error("receivers enabled in manual power-down");
  chk_auto_rx_on: assert property ($stable(two_pin) && two_pin
    && state == serial_pd_pkg::ST_AUTO_PD |=> rx_oe)
    else $error("receivers disabled in automatic power-down");
  chk_single_rx_gate: assert property (!two_pin |=> rx_oe == !$past(rx_enable_n_s))
    else $error("receiver enable not following rx_enable_n");
  chk_single_pd_rx: assert property (!two_pin && !rx_enable_n_s
    && state == serial_pd_pkg::ST_MANUAL_PD |=> rx_oe)
    else $error("receivers dropped in single-pin power-down");
  chk_sleep_dominates: assert property (two_pin && !force_sleep_n_s
    |=> state == serial_pd_pkg::ST_MANUAL_PD)
    else $error("force_sleep_n low did not force power-down");
  chk_forced_on: assert property (two_pin && force_sleep_n_s && hold_awake_s
    && state != serial_pd_pkg::ST_MANUAL_PD |=> state == serial_pd_pkg::ST_RUN)
    else $error("forced-on mode left running state");
  chk_tied_no_auto: assert property (two_pin && (force_sleep_n_s == hold_awake_s)
    |=> state != serial_pd_pkg::ST_AUTO_PD)
    else $error("automatic power-down with tied control pins");
  chk_single_pin_pd: assert property (!two_pin
    |=> state == ($past(power_down_n_s)
    ? serial_pd_pkg::ST_RUN : serial_pd_pkg::ST_MANUAL_PD))
    else $error("single-pin power-down not following pin");
  chk_resume_bound: assert property (wake_age <= RESUME_LIM)
    else $error("transmitters late after wake");
  chk_grace_sleep: assert property (state == serial_pd_pkg::ST_RUN && auto_en
    && !line_valid && grace_done && !manual_req
    |=> state == serial_pd_pkg::ST_AUTO_PD ##1 !supply_on)
    else $error("no automatic power-down after invalid line");
  chk_fall_persist: assert property ($fell(line_valid) |-> invalid_run > PERSIST_LIM)
    else $error("line_valid fell too early");
  chk_fall_timely: assert property (line_valid && !any_valid_h
    && invalid_run == PERSIST_LIM |=> !line_valid)
    else $error("line_valid fell late");
  chk_rise_delay: assert property ($rose(line_valid) |-> valid_run >= RECOVER_LIM)
    else $error("line_valid rose too early");
  chk_rise_timely: assert property (!line_valid && any_valid_h
    && valid_run == RECOVER_LIM - 1 |=> line_valid)
    else $error("line_valid rose late");
  chk_valid_any: assert property (invalid_run == 0 && valid_run > RECOVER_LIM
    |-> line_valid)
    else $error("line_valid low with valid input");
  chk_low_means_pd: assert property (auto_en && $stable(auto_en) && !line_valid
    && grace_done && !manual_req && state != serial_pd_pkg::ST_MANUAL_PD
    |=> is_powered_down(state))
    else $error("running while line invalid in auto mode");
  chk_auto_wake: assert property (state == serial_pd_pkg::ST_AUTO_PD && line_valid
    && !manual_req |=> state == serial_pd_pkg::ST_RUN ##1 supply_on)
    else $error("no wake on valid line");
  chk_auto_exit: assert property (state == serial_pd_pkg::ST_AUTO_PD && !auto_en
    && !manual_req |=> state == serial_pd_pkg::ST_RUN)
    else $error("automatic power-down held with auto disabled");
  chk_monitor_live: assert property (1'b1
    |=> monitor_rx_out == $past(rx_line_s[serial_pd_pkg::MON_IDX]))
    else $error("monitor output not following line");
  chk_rx_invert: assert property (1'b1 |=> rx_out == ~$past(rx_line_s))
    else $error("receiver outputs not inverting the line");

  cov_auto_pd: cover property (state == serial_pd_pkg::ST_RUN
    ##1 state == serial_pd_pkg::ST_AUTO_PD);
  cov_auto_wake: cover property (state == serial_pd_pkg::ST_AUTO_PD
    ##1 state == serial_pd_pkg::ST_RUN);
  cov_manual_two_pin: cover property (two_pin && state == serial_pd_pkg::ST_MANUAL_PD);
  cov_valid_fall: cover property ($fell(line_valid));
  cov_tx_resume: cover property ($rose(tx_oe));

endmodule
`default_nettype wire

// ---- logic/serial_pd_pkg.sv ----
// constants and types shared by the serial port power-mode control
// assumes a single 25 MHz clock and synchronised pin inputs
package serial_pd_pkg;

  localparam int CLK_MHZ = 25;
  localparam int N_RX = 5;
  localparam int MON_IDX = 0;
  localparam int CNT_W = 12;

  // times in microseconds
  localparam int T_PERSIST_US = 30;
  localparam int T_RECOVER_US = 1;
  localparam int T_RESUME_US = 100;
  localparam int T_GRACE_US = 30;

  // cycle counts derived from the clock rate
  localparam logic [CNT_W-1:0] PERSIST_CYC = CNT_W'(T_PERSIST_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] RECOVER_CYC = CNT_W'(T_RECOVER_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] RESUME_CYC = CNT_W'(T_RESUME_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] GRACE_CYC = CNT_W'(T_GRACE_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
  localparam int CFG_TWO_PIN_BIT = 0;
  localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_VALID_BIT = 2;
  localparam int ST_SUPPLY_BIT = 3;
  localparam int ST_TX_BIT = 4;
  localparam int ST_RX_BIT = 5;

  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_MANUAL = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_MANUAL_PD,
    ST_AUTO_PD
  } power_state_t;

endpackage

// ---- logic/pin_sync.sv ----
// two-flop synchroniser for a group of pin levels
// assumes pins are asynchronous to sys_clk
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      pin_sync_out <= '0;
    end else begin
      stage1 <= pin_in;
      pin_sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// ---- logic/line_valid_filter.sv ----
// line-valid status with fall persistence and rise recovery delay
// assumes synchronised per-input valid levels
`timescale 1ns/1ns
`default_nettype none
module line_valid_filter (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [serial_pd_pkg::N_RX-1:0] rx_valid,
  output logic line_valid
);

  logic any_valid;
  logic [serial_pd_pkg::CNT_W-1:0] run_cnt;

  assign any_valid = |rx_valid;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      line_valid <= 1'b0;
      run_cnt <= serial_pd_pkg::CNT_ZERO;
    end else if (line_valid) begin
      if (any_valid) begin
        run_cnt <= serial_pd_pkg::CNT_ZERO;
      end else if (run_cnt == serial_pd_pkg::PERSIST_CYC) begin
        line_valid <= 1'b0;
        run_cnt <= serial_pd_pkg::CNT_ZERO;
      end else begin
        run_cnt <= run_cnt + serial_pd_pkg::CNT_ONE;
      end
    end else begin
      if (!any_valid) begin
        run_cnt <= serial_pd_pkg::CNT_ZERO;
      end else if (run_cnt == serial_pd_pkg::RECOVER_CYC - serial_pd_pkg::CNT_ONE) begin
        line_valid <= 1'b1;
        run_cnt <= serial_pd_pkg::CNT_ZERO;
      end else begin
        run_cnt <= run_cnt + serial_pd_pkg::CNT_ONE;
      end
    end
  end

endmodule
`default_nettype wire

// ---- bench/rs232_peer.sv ----
// cable-side serial peripheral model feeding the receiver inputs
// assumes the bench drives its controls by non-blocking assignment at sys_clk
`timescale 1ns/1ns
`default_nettype none
module rs232_peer (
  input wire logic peer_on,
  input wire logic ring_only,
  input wire logic [serial_pd_pkg::N_RX-1:0] pattern,
  output logic [serial_pd_pkg::N_RX-1:0] rx_line,
  output logic [serial_pd_pkg::N_RX-1:0] rx_level_valid
);
  // ring only: peer drives input 0, the rest float
  assign rx_level_valid = !peer_on ? 5'h00 : (ring_only ? 5'h01 : 5'h1F);
  // undriven inputs sit on the receiver pull-downs
  assign rx_line = pattern & rx_level_valid;
endmodule
`default_nettype wire

// ---- bench/tb_serial_port_power_down_control.sv ----
// self-checking bench for the serial port power-mode control
// assumes the package, the design files and the peer model compile first
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_serial_port_power_down_control;
  typedef struct packed {
    logic cfg, pdn, en_n, fs, ha, ring;
    logic [4:0] pat;
    logic sup, oe;
    logic [1:0] mode;
  } row_t;
  row_t rows [8] = '{
    '{1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 5'h15, 1'h1, 1'h1, 2'h0},
    '{1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 5'h0A, 1'h1, 1'h0, 2'h0},
    '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 5'h01, 1'h0, 1'h1, 2'h1},
    '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 5'h1F, 1'h0, 1'h0, 2'h1},
    '{1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 5'h0A, 1'h0, 1'h0, 2'h1},
    '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 5'h15, 1'h0, 1'h0, 2'h1},
    '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 5'h1E, 1'h1, 1'h1, 2'h0},
    '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 5'h01, 1'h1, 1'h1, 2'h0}};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic power_down_n = 1'b1, rx_enable_n = 1'b0, force_sleep_n = 1'b1, hold_awake = 1'b1;
  logic peer_on = 1'b1, ring_only = 1'b0;
  logic [4:0] pattern = 5'h00;
  logic [4:0] rx_line, rx_level_valid, rx_out;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic supply_on, tx_oe, rx_oe, monitor_rx_out, line_valid;
  int error_cnt = 0;
  int cmp_count = 0;

  always #20 sys_clk = ~sys_clk;

  rs232_peer i_rs232_peer (.peer_on(peer_on), .ring_only(ring_only), .pattern(pattern),
    .rx_line(rx_line), .rx_level_valid(rx_level_valid));
  serial_power_ctrl i_serial_power_ctrl (.sys_clk(sys_clk), .rst(rst),
    .power_down_n(power_down_n), .rx_enable_n(rx_enable_n), .force_sleep_n(force_sleep_n),
    .hold_awake(hold_awake), .rx_line(rx_line), .rx_level_valid(rx_level_valid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .supply_on(supply_on), .tx_oe(tx_oe), .rx_out(rx_out),
    .rx_oe(rx_oe), .monitor_rx_out(monitor_rx_out), .line_valid(line_valid));

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // counts cycles until the chosen output reaches the level
  task automatic wait_sig(input int sel, input logic lvl, input int lim, output int n);
    n = 0;
    #1;
    while ((sel == 0 ? supply_on : sel == 1 ? tx_oe : line_valid) !== lvl && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
  endtask

  task automatic results();
    $display("errors %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    results();
  end

  initial begin
    logic [7:0] d;
    int n;
    row_t r;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    reg_read(serial_pd_pkg::REG_CONFIG, d);
    `CHK(d, serial_pd_pkg::CONFIG_RESET)
    reg_write(serial_pd_pkg::REG_CONFIG, 8'hA4);
    reg_read(serial_pd_pkg::REG_CONFIG, d);
    `CHK(d, 8'hA4)
    reg_write(4'h8, 8'hFF);
    reg_read(4'h8, d);
    `CHK(d, serial_pd_pkg::DATA_ZERO)
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      reg_write(serial_pd_pkg::REG_CONFIG, {7'h00, r.cfg});
      @(posedge sys_clk);
      power_down_n <= r.pdn;
      rx_enable_n <= r.en_n;
      force_sleep_n <= r.fs;
      hold_awake <= r.ha;
      ring_only <= r.ring;
      pattern <= r.pat;
      repeat (40) @(posedge sys_clk);
      #1;
      `CHK(supply_on, r.sup)
      `CHK(rx_oe, r.oe)
      `CHK(line_valid, 1'b1)
      `CHK(monitor_rx_out, r.pat[0])
      `CHK(rx_out, ~(r.pat & (r.ring ? 5'h01 : 5'h1F)))
      reg_read(serial_pd_pkg::REG_STATUS, d);
      `CHK(d[1:0], r.mode)
    end
    // forced sleep, then forced wake and transmitter resume
    @(posedge sys_clk);
    ring_only <= 1'b0;
    force_sleep_n <= 1'b0;
    wait_sig(0, 1'b0, 10, n);
    `CHK({supply_on, tx_oe}, 2'h0)
    @(posedge sys_clk);
    force_sleep_n <= 1'b1;
    hold_awake <= 1'b1;
    wait_sig(0, 1'b1, 10, n);
    wait_sig(1, 1'b1, 3000, n);
    `CHK(n <= 2501, 1'b1)
    // cable pulled with automatic power-down enabled
    @(posedge sys_clk);
    hold_awake <= 1'b0;
    peer_on <= 1'b0;
    wait_sig(2, 1'b0, 1000, n);
    `CHK((n > 750) && (n < 760), 1'b1)
    wait_sig(0, 1'b0, 5, n);
    `CHK({supply_on, tx_oe, rx_oe}, 3'h1)
    reg_read(serial_pd_pkg::REG_STATUS, d);
    `CHK(d[2:0], {1'b0, serial_pd_pkg::MODE_AUTO})
    // valid level returns
    @(posedge sys_clk);
    peer_on <= 1'b1;
    wait_sig(2, 1'b1, 100, n);
    `CHK((n >= 25) && (n <= 30), 1'b1)
    wait_sig(0, 1'b1, 5, n);
    `CHK(supply_on, 1'b1)
    @(posedge sys_clk);
    peer_on <= 1'b0;
    wait_sig(0, 1'b0, 900, n);
    `CHK(supply_on, 1'b0)
    // short dropout must not clear line-valid
    @(posedge sys_clk);
    peer_on <= 1'b1;
    repeat (60) @(posedge sys_clk);
    peer_on <= 1'b0;
    repeat (200) @(posedge sys_clk);
    peer_on <= 1'b1;
    #1;
    `CHK(line_valid, 1'b1)
    // forced awake with cable gone
    @(posedge sys_clk);
    hold_awake <= 1'b1;
    peer_on <= 1'b0;
    repeat (1000) @(posedge sys_clk);
    #1;
    `CHK({supply_on, line_valid}, 2'h2)
    // control pins tied together, then hold_awake alone dropped and raised
    @(posedge sys_clk);
    force_sleep_n <= 1'b0;
    hold_awake <= 1'b0;
    wait_sig(0, 1'b0, 10, n);
    reg_read(serial_pd_pkg::REG_STATUS, d);
    `CHK(d[1:0], serial_pd_pkg::MODE_MANUAL)
    @(posedge sys_clk);
    force_sleep_n <= 1'b1;
    hold_awake <= 1'b1;
    wait_sig(0, 1'b1, 10, n);
    `CHK(supply_on, 1'b1)
    @(posedge sys_clk);
    hold_awake <= 1'b0;
    wait_sig(0, 1'b0, 900, n);
    `CHK(supply_on, 1'b0)
    @(posedge sys_clk);
    hold_awake <= 1'b1;
    wait_sig(0, 1'b1, 6, n);
    `CHK(supply_on, 1'b1)
    // reset in mid-run
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    `CHK({supply_on, tx_oe, rx_oe, line_valid}, 4'h0)
    @(posedge sys_clk);
    rst <= 1'b0;
    reg_read(serial_pd_pkg::REG_CONFIG, d);
    `CHK(d, serial_pd_pkg::CONFIG_RESET)
    `CHK(supply_on, 1'b0)
    wait_sig(0, 1'b1, 10, n);
    `CHK(supply_on, 1'b1)
    results();
  end
endmodule
`default_nettype wire
